// ### ata_shadow_task_file.sv
// shadow task-file register block of a serial storage drive
`timescale 1ns/1ns
module ata_shadow_task_file #(
	parameter int READY_CYCLES = task_file_pkg::READY_CYCLES,
	parameter logic UNIT_ID = 1'b0
) (
	input wire logic clk_in,
	input wire logic reset_n_in,
	input wire logic tf_wr_in,
	input wire logic tf_rd_in,
	input wire logic tf_ctrl_sel_in,
	input wire logic [2:0] tf_addr_in,
	input wire logic [7:0] tf_wdata_in,
	output logic [7:0] tf_rdata_out,
	output logic tf_rvalid_out,
	output logic host_interrupt_line_out,
	output logic cmd_start_out,
	output logic [7:0] cmd_code_out,
	output logic [15:0] cmd_features_out,
	output logic [47:0] cmd_lba_out,
	output logic [16:0] cmd_count_out,
	output logic cmd_lba_mode_out,
	output logic cmd_ext_out,
	input wire logic done_in,
	input wire logic [7:0] err_bits_in,
	input wire logic [47:0] result_lba_in,
	input wire logic [15:0] remaining_in,
	input wire logic drq_in,
	input wire logic write_fault_in,
	input wire logic seek_start_in,
	input wire logic seek_done_in,
	input wire logic standby_in,
	input wire logic index_in
);
	localparam int CNT_W = $clog2(READY_CYCLES + 1);

	if (READY_CYCLES < 1) begin : g_chk
		$error("READY_CYCLES must be at least one");
	end
	typedef struct packed {
		task_file_pkg::state_t st;
		logic [CNT_W-1:0] ready_cnt;
		logic [7:0] dh;
		logic [7:0] err;
		logic err_st;
		logic upper_byte_view;
		logic software_hold_reset;
		logic interrupt_mask_bar;
		logic seek_now;
		logic positioning_done_flag;
		logic dsc_frozen;
		logic idx;
		logic [7:0] rdata;
		logic rvalid;
		logic irq;
		logic start;
		logic [7:0] code;
		logic [15:0] feat;
		logic [47:0] lba;
		logic [16:0] cnt;
		logic lmode;
		logic ext;
	} tf_state_t;
	tf_state_t s_r, s_nxt;

	logic busy;
	logic ready;
	logic wr_cmdblk;
	logic wr_ctrl;
	logic stat_rd;
	logic done_ok;
	logic done_good;
	logic irq_pend;
	logic wfault;
	logic hold;
	logic [7:0] status;
	logic [7:0] hist_rec [task_file_pkg::HIST_NUM];
	logic [7:0] hist_prv [task_file_pkg::HIST_NUM];
	logic [7:0] hist_ld_rec [task_file_pkg::HIST_NUM];
	logic [7:0] hist_ld_prv [task_file_pkg::HIST_NUM];
	logic [15:0] cnt16;
	logic cmd_ext;

	assign busy = s_r.st != task_file_pkg::ST_IDLE;
	assign ready = s_r.st != task_file_pkg::ST_POWERUP && s_r.st != task_file_pkg::ST_HOLD;
	// task-file writes are dropped while occupied; control writes always land so a hold can be released
	assign wr_cmdblk = tf_wr_in && !tf_ctrl_sel_in && !busy;
	assign wr_ctrl = tf_wr_in && tf_ctrl_sel_in;
	assign stat_rd = tf_rd_in && !tf_ctrl_sel_in && tf_addr_in == task_file_pkg::OFS_STATE_COMMAND;
	assign done_ok = done_in && s_r.st == task_file_pkg::ST_EXEC;
	assign done_good = done_ok && (err_bits_in & task_file_pkg::ERR_LIVE_MASK) == 8'h00;
	assign hold = s_r.st == task_file_pkg::ST_HOLD;

	always_comb begin
		status = 8'h00;
		status[task_file_pkg::ST_OCCUPIED_BIT] = busy;
		status[task_file_pkg::ST_ACCEPTING_BIT] = ready;
		status[task_file_pkg::ST_WRITE_FAULT_BIT] = wfault;
		status[task_file_pkg::ST_POSITIONING_BIT] = s_r.positioning_done_flag;
		status[task_file_pkg::ST_TRANSFER_REQ_BIT] = drq_in;
		status[task_file_pkg::ST_FIXED_DATA_BIT] = 1'b0;
		status[task_file_pkg::ST_ROTATION_BIT] = s_r.idx;
		status[task_file_pkg::ST_ERROR_BIT] = s_r.err_st;
	end
	// completion values for count, low, mid and high; features never loads
	always_comb begin
		hist_ld_rec[0] = hist_rec[0];
		hist_ld_prv[0] = hist_prv[0];
		hist_ld_rec[task_file_pkg::HIST_COUNT] = done_good ? 8'h00 : remaining_in[7:0];
		hist_ld_prv[task_file_pkg::HIST_COUNT] = done_good ? 8'h00 : remaining_in[15:8];
		hist_ld_rec[2] = result_lba_in[7:0];
		hist_ld_prv[2] = s_r.ext ? result_lba_in[31:24] : hist_prv[2];
		hist_ld_rec[3] = result_lba_in[15:8];
		hist_ld_prv[3] = s_r.ext ? result_lba_in[39:32] : hist_prv[3];
		hist_ld_rec[4] = result_lba_in[23:16];
		hist_ld_prv[4] = s_r.ext ? result_lba_in[47:40] : hist_prv[4];
	end

	for (genvar g = 0; g < task_file_pkg::HIST_NUM; g++) begin : g_hist
		byte_history #(
			.WIDTH(8)
		) u_hist (
			.clk_in(clk_in),
			.reset_n_in(reset_n_in),
			.clear_in(hold),
			.write_in(wr_cmdblk && tf_addr_in == 3'(g + 1)),
			.wdata_in(tf_wdata_in),
			.load_in(done_ok && g != 0),
			.load_recent_in(hist_ld_rec[g]),
			.load_prev_in(hist_ld_prv[g]),
			.recent_out(hist_rec[g]),
			.prev_out(hist_prv[g])
		);
	end

	sticky_flag u_irq_pend (
		.clk_in(clk_in),
		.reset_n_in(reset_n_in),
		.set_in(done_ok),
		.clear_in(stat_rd || hold),
		.flag_out(irq_pend)
	);
	sticky_flag u_wfault (
		.clk_in(clk_in),
		.reset_n_in(reset_n_in),
		.set_in(write_fault_in),
		.clear_in(stat_rd),
		.flag_out(wfault)
	);

	assign cmd_ext = task_file_pkg::is_ext_cmd(tf_wdata_in);
	assign cnt16 = cmd_ext ? {hist_prv[task_file_pkg::HIST_COUNT], hist_rec[task_file_pkg::HIST_COUNT]}
		: {8'h00, hist_rec[task_file_pkg::HIST_COUNT]};

	always_comb begin
		s_nxt = s_r;
		s_nxt.start = 1'b0;
		s_nxt.rvalid = 1'b0;
		s_nxt.idx = index_in;
		case (s_r.st)
			task_file_pkg::ST_POWERUP: begin
				// no command is taken until the power-up delay has run out
				if (s_r.ready_cnt == CNT_W'(READY_CYCLES - 1)) begin
					s_nxt.st = task_file_pkg::ST_IDLE;
				end else begin
					s_nxt.ready_cnt = s_r.ready_cnt + CNT_W'(1);
				end
			end
			task_file_pkg::ST_IDLE: begin
				if (wr_cmdblk && tf_addr_in == task_file_pkg::OFS_STATE_COMMAND) begin
					s_nxt.st = task_file_pkg::ST_EXEC;
					s_nxt.start = 1'b1;
					s_nxt.code = tf_wdata_in;
					s_nxt.ext = cmd_ext;
					s_nxt.lmode = s_r.dh[task_file_pkg::DH_LBA_MODE_BIT];
					s_nxt.feat = {hist_prv[0], hist_rec[0]};
					if (cmd_ext) begin
						s_nxt.lba = {hist_prv[4], hist_prv[3], hist_prv[2], hist_rec[4], hist_rec[3], hist_rec[2]};
					end else begin
						s_nxt.lba = {20'h0_0000, s_r.dh[task_file_pkg::DH_HEAD_MSB:0],
							hist_rec[4], hist_rec[3], hist_rec[2]};
					end
					if (cnt16 == 16'h0000) begin
						s_nxt.cnt = cmd_ext ? task_file_pkg::COUNT_ZERO_48 : task_file_pkg::COUNT_ZERO_28;
					end else begin
						s_nxt.cnt = {1'b0, cnt16};
					end
				end
			end
			task_file_pkg::ST_EXEC: begin
				if (done_ok) begin
					s_nxt.st = task_file_pkg::ST_IDLE;
					s_nxt.err = err_bits_in & task_file_pkg::ERR_LIVE_MASK;
					s_nxt.err_st = !done_good;
					if (!s_r.ext) begin
						s_nxt.dh[task_file_pkg::DH_HEAD_MSB:0] = result_lba_in[27:24];
					end
				end
			end
			task_file_pkg::ST_HOLD: begin
				s_nxt.dh = task_file_pkg::DRIVE_HEAD_RESET;
				s_nxt.err = task_file_pkg::ERROR_RESET;
				s_nxt.err_st = 1'b0;
			end
			default: begin
				s_nxt.st = task_file_pkg::ST_POWERUP;
			end
		endcase
		if (wr_cmdblk && tf_addr_in == task_file_pkg::OFS_DRIVE_HEAD) begin
			s_nxt.dh = tf_wdata_in;
		end
		if (wr_cmdblk) begin
			s_nxt.upper_byte_view = 1'b0;
		end
		if (wr_ctrl) begin
			s_nxt.upper_byte_view = tf_wdata_in[task_file_pkg::CTL_UPPER_BYTE_VIEW_BIT];
			s_nxt.interrupt_mask_bar = tf_wdata_in[task_file_pkg::CTL_INTERRUPT_MASK_BAR_BIT];
			s_nxt.software_hold_reset = tf_wdata_in[task_file_pkg::CTL_SOFTWARE_HOLD_RESET_BIT];
			if (tf_wdata_in[task_file_pkg::CTL_SOFTWARE_HOLD_RESET_BIT]) begin
				s_nxt.st = task_file_pkg::ST_HOLD;
			end else if (s_r.st == task_file_pkg::ST_HOLD) begin
				s_nxt.st = task_file_pkg::ST_IDLE;
			end
		end
		// positioning flag tracks seeks, but an error freezes the shown value until status is read unless standby sets it
		if (seek_start_in) begin
			s_nxt.seek_now = 1'b0;
		end else if (seek_done_in) begin
			s_nxt.seek_now = 1'b1;
		end
		if (done_ok && !done_good) begin
			s_nxt.dsc_frozen = 1'b1;
		end else if (stat_rd) begin
			s_nxt.dsc_frozen = 1'b0;
		end
		if (standby_in) begin
			s_nxt.positioning_done_flag = 1'b1;
		end else if (!(s_r.dsc_frozen && !stat_rd)) begin
			s_nxt.positioning_done_flag = s_nxt.seek_now;
		end
		if (tf_rd_in) begin
			s_nxt.rvalid = 1'b1;
			if (busy || tf_ctrl_sel_in) begin
				s_nxt.rdata = status;
			end else begin
				case (tf_addr_in)
					task_file_pkg::OFS_DATA: s_nxt.rdata = 8'h00;
					task_file_pkg::OFS_ERROR_FEATURES: s_nxt.rdata = s_r.err;
					task_file_pkg::OFS_DRIVE_HEAD: s_nxt.rdata = s_r.dh;
					task_file_pkg::OFS_STATE_COMMAND: s_nxt.rdata = status;
					default: begin
						s_nxt.rdata = s_r.upper_byte_view ? hist_prv[tf_addr_in - 3'h1] : hist_rec[tf_addr_in - 3'h1];
					end
				endcase
			end
		end
		// gate uses the next mask and unit so a masked drive never raises the line
		s_nxt.irq = irq_pend && !s_nxt.interrupt_mask_bar && s_nxt.dh[task_file_pkg::DH_UNIT_SELECT_BIT] == UNIT_ID;
		if (stat_rd || s_nxt.st == task_file_pkg::ST_HOLD) begin
			s_nxt.irq = 1'b0;
		end
	end

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			s_r <= '0;
			s_r.st <= task_file_pkg::ST_POWERUP;
			s_r.dh <= task_file_pkg::DRIVE_HEAD_RESET;
			s_r.err <= task_file_pkg::ERROR_RESET;
			s_r.rdata <= task_file_pkg::BYTE_RESET;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign tf_rdata_out = s_r.rdata;
	assign tf_rvalid_out = s_r.rvalid;
	assign host_interrupt_line_out = s_r.irq;
	assign cmd_start_out = s_r.start;
	assign cmd_code_out = s_r.code;
	assign cmd_features_out = s_r.feat;
	assign cmd_lba_out = s_r.lba;
	assign cmd_count_out = s_r.cnt;
	assign cmd_lba_mode_out = s_r.lmode;
	assign cmd_ext_out = s_r.ext;

	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!reset_n_in);
	property p_cmd_start;
		wr_cmdblk && tf_addr_in == task_file_pkg::OFS_STATE_COMMAND && !wr_ctrl
			|=> cmd_start_out && cmd_code_out == $past(tf_wdata_in) ##1 !cmd_start_out;
	endproperty
	a_cmd_start: assert property (p_cmd_start) else $error("command write did not start execution");

	property p_hob_clear;
		wr_cmdblk && !wr_ctrl |=> !s_r.upper_byte_view;
	endproperty
	a_hob_clear: assert property (p_hob_clear) else $error("upper byte view not cleared by write");

	property p_hold_busy;
		wr_ctrl && tf_wdata_in[task_file_pkg::CTL_SOFTWARE_HOLD_RESET_BIT] ##1 !wr_ctrl ##1 tf_rd_in
			|=> tf_rvalid_out && tf_rdata_out[task_file_pkg::ST_OCCUPIED_BIT];
	endproperty
	a_hold_busy: assert property (p_hold_busy) else $error("hold reset did not show occupied");

	property p_irq_gate;
		host_interrupt_line_out |-> !s_r.interrupt_mask_bar && s_r.dh[task_file_pkg::DH_UNIT_SELECT_BIT] == UNIT_ID && $past(irq_pend);
	endproperty
	a_irq_gate: assert property (p_irq_gate) else $error("interrupt raised while masked or deselected");

	property p_count_success;
		done_good |=> hist_rec[task_file_pkg::HIST_COUNT] == 8'h00 && !busy && !s_r.err_st;
	endproperty
	a_count_success: assert property (p_count_success) else $error("count not zero after success");

	property p_busy_read;
		tf_rd_in && busy |=> tf_rvalid_out && tf_rdata_out[task_file_pkg::ST_OCCUPIED_BIT];
	endproperty
	a_busy_read: assert property (p_busy_read) else $error("read while occupied did not return status");

	property p_status_clears_irq;
		stat_rd && !done_ok |=> !host_interrupt_line_out ##1 !host_interrupt_line_out;
	endproperty
	a_status_clears_irq: assert property (p_status_clears_irq) else $error("status read left interrupt up");

	property p_fixed_zero;
		tf_rvalid_out && $past(stat_rd) |-> !tf_rdata_out[task_file_pkg::ST_FIXED_DATA_BIT];
	endproperty
	a_fixed_zero: assert property (p_fixed_zero) else $error("fixed data flag read as one");

	property p_err_reserved;
		(s_r.err & ~task_file_pkg::ERR_LIVE_MASK) == 8'h00;
	endproperty
	a_err_reserved: assert property (p_err_reserved) else $error("reserved error bits set");

	property p_not_ready_powerup;
		s_r.st == task_file_pkg::ST_POWERUP |-> !ready ##1 (s_r.st != task_file_pkg::ST_EXEC);
	endproperty
	a_not_ready_powerup: assert property (p_not_ready_powerup) else $error("ready during power-up");

	c_cmd_done: cover property (cmd_start_out ##[1:50] done_good);
	c_cmd_error: cover property (done_ok && !done_good ##[1:20] stat_rd);
	c_hold_release: cover property (hold ##[1:50] s_r.st == task_file_pkg::ST_IDLE);
endmodule // ata_shadow_task_file

// ### byte_history.sv
// two-deep register history for one shadow register
`timescale 1ns/1ns
module byte_history #(
	parameter int WIDTH = 8
) (
	input wire logic clk_in,
	input wire logic reset_n_in,
	input wire logic clear_in,
	input wire logic write_in,
	input wire logic [WIDTH-1:0] wdata_in,
	input wire logic load_in,
	input wire logic [WIDTH-1:0] load_recent_in,
	input wire logic [WIDTH-1:0] load_prev_in,
	output logic [WIDTH-1:0] recent_out,
	output logic [WIDTH-1:0] prev_out
);
	typedef struct packed {
		logic [WIDTH-1:0] recent;
		logic [WIDTH-1:0] prev;
	} hist_state_t;
	hist_state_t s_r, s_nxt;

	if (WIDTH < 1) begin : g_chk
		$error("byte_history width must be positive");
	end

	always_comb begin
		s_nxt = s_r;
		if (clear_in) begin
			s_nxt = '0;
		end else if (load_in) begin
			s_nxt.recent = load_recent_in;
			s_nxt.prev = load_prev_in;
		end else if (write_in) begin
			s_nxt.prev = s_r.recent;
			s_nxt.recent = wdata_in;
		end
	end

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign recent_out = s_r.recent;
	assign prev_out = s_r.prev;

	property p_history_shift;
		@(posedge clk_in) disable iff (!reset_n_in)
		write_in && !clear_in && !load_in |=> prev_out == $past(recent_out) && recent_out == $past(wdata_in);
	endproperty
	a_history_shift: assert property (p_history_shift) else $error("history did not shift on write");
endmodule // byte_history

// ### host_port_model.sv
// host-side model that drives the shadow register port
`timescale 1ns/1ns
module host_port_model (
	input wire logic clk_in,
	input wire logic [7:0] rdata_in,
	input wire logic rvalid_in,
	output logic wr_out,
	output logic rd_out,
	output logic ctrl_sel_out,
	output logic [2:0] addr_out,
	output logic [7:0] wdata_out
);
	initial begin
		wr_out = 1'b0;
		rd_out = 1'b0;
		ctrl_sel_out = 1'b0;
		addr_out = 3'h0;
		wdata_out = 8'h00;
	end
	// callers load parameters before the command write
	task automatic write_reg(input logic c, input logic [2:0] a, input logic [7:0] d);
		@(posedge clk_in);
		#1;
		ctrl_sel_out = c;
		addr_out = a;
		wdata_out = d;
		wr_out = 1'b1;
		@(posedge clk_in);
		#1;
		wr_out = 1'b0;
		wdata_out = ~d;
	endtask
	task automatic read_reg(input logic c, input logic [2:0] a, output logic [7:0] d, output logic v);
		@(posedge clk_in);
		#1;
		ctrl_sel_out = c;
		addr_out = a;
		rd_out = 1'b1;
		@(posedge clk_in);
		#1;
		rd_out = 1'b0;
		v = rvalid_in;
		d = rdata_in;
	endtask
	// polls alternate status so no interrupt is acknowledged by the wait
	task automatic wait_idle(output logic ok);
		logic [7:0] s;
		logic v;
		ok = 1'b0;
		for (int i = 0; i < 32 && !ok; i++) begin
			read_reg(1'b1, 3'h6, s, v);
			ok = v && !s[7];
		end
	endtask
endmodule // host_port_model

// ### sticky_flag.sv
// sticky event flag, set wins over clear
`timescale 1ns/1ns
module sticky_flag (
	input wire logic clk_in,
	input wire logic reset_n_in,
	input wire logic set_in,
	input wire logic clear_in,
	output logic flag_out
);
	typedef struct packed {
		logic flag;
	} flag_state_t;
	flag_state_t s_r, s_nxt;

	always_comb begin
		s_nxt = s_r;
		// an event in the clearing cycle must not be lost
		s_nxt.flag = set_in | (s_r.flag & ~clear_in);
	end

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign flag_out = s_r.flag;

	property p_set_wins;
		@(posedge clk_in) disable iff (!reset_n_in)
		set_in |=> flag_out;
	endproperty
	a_set_wins: assert property (p_set_wins) else $error("flag lost a set event");
endmodule // sticky_flag

// ### task_file_pkg.sv
// constants, types and helpers shared by the shadow task-file block
package task_file_pkg;
	// command-block register offsets on the task-file port
	localparam logic [2:0] OFS_DATA = 3'h0;
	localparam logic [2:0] OFS_ERROR_FEATURES = 3'h1;
	localparam logic [2:0] OFS_COUNT = 3'h2;
	localparam logic [2:0] OFS_ADDR_LOW = 3'h3;
	localparam logic [2:0] OFS_ADDR_MID = 3'h4;
	localparam logic [2:0] OFS_ADDR_HIGH = 3'h5;
	localparam logic [2:0] OFS_DRIVE_HEAD = 3'h6;
	localparam logic [2:0] OFS_STATE_COMMAND = 3'h7;
	// drive_control fields
	localparam int CTL_UPPER_BYTE_VIEW_BIT = 7;
	localparam int CTL_SOFTWARE_HOLD_RESET_BIT = 2;
	localparam int CTL_INTERRUPT_MASK_BAR_BIT = 1;
	// drive_head_select fields
	localparam int DH_LBA_MODE_BIT = 6;
	localparam int DH_UNIT_SELECT_BIT = 4;
	localparam int DH_HEAD_MSB = 3;
	// drive_state fields
	localparam int ST_OCCUPIED_BIT = 7;
	localparam int ST_ACCEPTING_BIT = 6;
	localparam int ST_WRITE_FAULT_BIT = 5;
	localparam int ST_POSITIONING_BIT = 4;
	localparam int ST_TRANSFER_REQ_BIT = 3;
	localparam int ST_FIXED_DATA_BIT = 2;
	localparam int ST_ROTATION_BIT = 1;
	localparam int ST_ERROR_BIT = 0;
	// error_cause: bits 7,6,4,2,1,0 live, 5 and 3 read zero
	localparam logic [7:0] ERR_LIVE_MASK = 8'hd7;
	// reset values
	localparam logic [7:0] DRIVE_HEAD_RESET = 8'h00;
	localparam logic [7:0] BYTE_RESET = 8'h00;
	localparam logic [7:0] ERROR_RESET = 8'h00;
	// zero sector count meanings
	localparam logic [16:0] COUNT_ZERO_28 = 17'h0_0100;
	localparam logic [16:0] COUNT_ZERO_48 = 17'h1_0000;
	// power-up delay before commands are accepted
	localparam int CLK_PERIOD_NS = 8;
	localparam int READY_DELAY_NS = 1000;
	localparam int READY_CYCLES = (READY_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// history slots: features, count, low, mid, high
	localparam int HIST_NUM = 5;
	localparam int HIST_COUNT = 1;

	typedef enum logic [1:0] {
		ST_POWERUP = 2'b00,
		ST_IDLE = 2'b01,
		ST_EXEC = 2'b11,
		ST_HOLD = 2'b10
	} state_t;

	// commands that carry 48-bit addresses and 16-bit counts
	function automatic logic is_ext_cmd(input logic [7:0] code);
		case (code)
			8'h24, 8'h25, 8'h27, 8'h29, 8'h2f, 8'h34, 8'h35, 8'h37,
			8'h39, 8'h3d, 8'h3f, 8'h42, 8'h45, 8'h47, 8'h57, 8'hce: return 1'b1;
			default: return 1'b0;
		endcase
	endfunction
endpackage

// ### test_ata_shadow_task_file.sv
// self-checking bench for the shadow task-file block
`timescale 1ns/1ns
module test_ata_shadow_task_file;
	logic clk_in, reset_n_in, tf_wr, tf_rd, tf_ctrl_sel, tf_rvalid, host_irq, cmd_start, cmd_lba_mode, cmd_ext, ok;
	logic done, transfer_request_flag, write_fault, seek_start, seek_done, standby, index;
	logic [2:0] tf_addr;
	logic [7:0] tf_wdata, tf_rdata, cmd_code, err_bits, cnt;
	logic [15:0] cmd_features, remaining, rem, feat;
	logic [16:0] cmd_count;
	logic [47:0] cmd_lba, result_lba, lba, res;
	int mismatches = 0;
	int total_checks = 0;
	initial begin
		clk_in = 1'b0;
		forever #4 clk_in = ~clk_in;
	end
	ata_shadow_task_file #(.READY_CYCLES(4), .UNIT_ID(1'b0)) i_ata_shadow_task_file (.clk_in(clk_in),
		.reset_n_in(reset_n_in), .tf_wr_in(tf_wr), .tf_rd_in(tf_rd), .tf_ctrl_sel_in(tf_ctrl_sel),
		.tf_addr_in(tf_addr), .tf_wdata_in(tf_wdata), .tf_rdata_out(tf_rdata), .tf_rvalid_out(tf_rvalid),
		.host_interrupt_line_out(host_irq), .cmd_start_out(cmd_start), .cmd_code_out(cmd_code),
		.cmd_features_out(cmd_features), .cmd_lba_out(cmd_lba), .cmd_count_out(cmd_count),
		.cmd_lba_mode_out(cmd_lba_mode), .cmd_ext_out(cmd_ext), .done_in(done), .err_bits_in(err_bits),
		.result_lba_in(result_lba), .remaining_in(remaining), .drq_in(transfer_request_flag), .write_fault_in(write_fault),
		.seek_start_in(seek_start), .seek_done_in(seek_done), .standby_in(standby), .index_in(index));
	host_port_model i_host_port_model (.clk_in(clk_in), .rdata_in(tf_rdata), .rvalid_in(tf_rvalid),
		.wr_out(tf_wr), .rd_out(tf_rd), .ctrl_sel_out(tf_ctrl_sel), .addr_out(tf_addr), .wdata_out(tf_wdata));
	task automatic chk(input logic [47:0] got, input logic [47:0] exp);
		total_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic tick();
		@(posedge clk_in);
		#1;
	endtask
	task automatic wr(input logic c, input logic [2:0] a, input logic [7:0] d);
		i_host_port_model.write_reg(c, a, d);
	endtask
	task automatic rdc(input logic c, input logic [2:0] a, input logic [7:0] exp, input logic [7:0] mask);
		logic [7:0] d;
		logic v;
		i_host_port_model.read_reg(c, a, d, v);
		chk(v, 1'b1);
		chk(d & mask, exp & mask);
	endtask
	task automatic pulse(ref logic s);
		tick();
		s = 1'b1;
		tick();
		s = 1'b0;
	endtask
	task automatic complete(input logic [7:0] e, input logic [47:0] r, input logic [15:0] n);
		tick();
		done = 1'b1;
		err_bits = e;
		result_lba = r;
		remaining = n;
		tick();
		done = 1'b0;
		err_bits = ~e;
		result_lba = ~r;
	endtask
	function automatic logic [16:0] exp_count(input logic [15:0] c, input logic ext);
		if (c == 16'h0000) begin
			return ext ? 17'h1_0000 : 17'h0_0100;
		end
		return {1'b0, c};
	endfunction
	task automatic finish_test();
		if (mismatches == 0 && total_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	initial begin
		#100000;
		mismatches++;
		finish_test();
	end
	initial begin
		{reset_n_in, done, transfer_request_flag, write_fault, seek_start, seek_done, standby, index} = 8'h00;
		err_bits = 8'h00;
		result_lba = 48'h0;
		remaining = 16'h0000;
		void'($urandom(32'he878));
		repeat (5) @(posedge clk_in);
		#1;
		reset_n_in = 1'b1;
		rdc(1'b1, 3'h6, 8'h80, 8'hc4);
		i_host_port_model.wait_idle(ok);
		chk(ok, 1'b1);
		rdc(1'b0, 3'h7, 8'h40, 8'hc5);
		for (int i = 0; i < 4; i++) begin
			lba = {20'h0, 28'($urandom)};
			cnt = (i == 0) ? 8'h00 : 8'($urandom);
			wr(1'b0, 3'h2, cnt);
			wr(1'b0, 3'h3, lba[7:0]);
			wr(1'b0, 3'h4, lba[15:8]);
			wr(1'b0, 3'h5, lba[23:16]);
			wr(1'b0, 3'h6, {4'h4, lba[27:24]});
			wr(1'b0, 3'h7, 8'hc8);
			chk(cmd_start, 1'b1);
			chk({cmd_lba_mode, cmd_ext, cmd_code}, {2'b10, 8'hc8});
			chk(cmd_lba, lba);
			chk(cmd_count, exp_count({8'h00, cnt}, 1'b0));
			rdc(1'b0, 3'h2, 8'h80, 8'h80);
			res = {20'h0, 28'($urandom)};
			complete(8'h00, res, 16'($urandom));
			tick();
			chk(host_irq, 1'b1);
			rdc(1'b0, 3'h3, res[7:0], 8'hff);
			rdc(1'b0, 3'h4, res[15:8], 8'hff);
			rdc(1'b0, 3'h5, res[23:16], 8'hff);
			rdc(1'b0, 3'h6, {4'h4, res[27:24]}, 8'hff);
			rdc(1'b0, 3'h2, 8'h00, 8'hff);
			rdc(1'b0, 3'h7, 8'h40, 8'hc5);
			tick();
			chk(host_irq, 1'b0);
		end
		// 48-bit values go in upper bytes first, each write pushes the older slot
		lba = {16'($urandom), 32'($urandom)};
		feat = 16'($urandom);
		for (int j = 1; j >= 0; j--) begin
			wr(1'b0, 3'h1, feat[8*j+:8]);
			wr(1'b0, 3'h2, 8'h00);
			wr(1'b0, 3'h3, lba[24*j+:8]);
			wr(1'b0, 3'h4, lba[24*j+8+:8]);
			wr(1'b0, 3'h5, lba[24*j+16+:8]);
		end
		wr(1'b0, 3'h6, 8'h40);
		wr(1'b0, 3'h7, 8'h25);
		chk({cmd_ext, cmd_lba}, {1'b1, lba});
		chk(cmd_count, exp_count(16'h0000, 1'b1));
		chk(cmd_features, feat);
		rem = 16'($urandom) | 16'h0101;
		res = {16'($urandom), 32'($urandom)};
		complete(8'hff, res, rem);
		rdc(1'b0, 3'h1, 8'hd7, 8'hff);
		rdc(1'b0, 3'h2, rem[7:0], 8'hff);
		wr(1'b1, 3'h6, 8'h80);
		rdc(1'b0, 3'h2, rem[15:8], 8'hff);
		rdc(1'b0, 3'h4, res[39:32], 8'hff);
		rdc(1'b0, 3'h3, res[31:24], 8'hff);
		wr(1'b0, 3'h1, 8'h00);
		rdc(1'b0, 3'h2, rem[7:0], 8'hff);
		pulse(seek_done);
		rdc(1'b1, 3'h6, 8'h00, 8'h10);
		rdc(1'b0, 3'h7, 8'h41, 8'hc5);
		rdc(1'b1, 3'h6, 8'h10, 8'h10);
		pulse(write_fault);
		rdc(1'b1, 3'h6, 8'h20, 8'h20);
		rdc(1'b0, 3'h7, 8'h20, 8'h20);
		rdc(1'b0, 3'h7, 8'h00, 8'h20);
		pulse(seek_start);
		rdc(1'b1, 3'h6, 8'h00, 8'h10);
		pulse(seek_done);
		rdc(1'b1, 3'h6, 8'h10, 8'h10);
		pulse(seek_start);
		standby = 1'b1;
		rdc(1'b1, 3'h6, 8'h10, 8'h10);
		standby = 1'b0;
		transfer_request_flag = 1'b1;
		index = 1'b1;
		rdc(1'b1, 3'h6, 8'h0a, 8'h0a);
		transfer_request_flag = 1'b0;
		index = 1'b0;
		// masked, then other unit selected: neither may raise the line
		for (int k = 0; k < 2; k++) begin
			wr(1'b1, 3'h6, k ? 8'h00 : 8'h02);
			wr(1'b0, 3'h6, k ? 8'h50 : 8'h40);
			wr(1'b0, 3'h7, 8'he7);
			complete(8'h00, 48'h0, 16'h0000);
			repeat (3) begin
				tick();
				chk(host_irq, 1'b0);
			end
			rdc(1'b0, 3'h7, 8'h40, 8'hc1);
		end
		wr(1'b1, 3'h6, 8'h04);
		rdc(1'b1, 3'h6, 8'h80, 8'hc0);
		rdc(1'b0, 3'h5, 8'h80, 8'h80);
		wr(1'b1, 3'h6, 8'h00);
		rdc(1'b1, 3'h6, 8'h40, 8'hc0);
		finish_test();
	end
endmodule // test_ata_shadow_task_file
